//--- pkg/wdt_rst_cfg.svh
// Constants of the watchdog and reset control block.
// How it works
// - Key 10101B keeps the watchdog disabled.
// - Key 01010B runs the watchdog.
// - Other key values reset after delay.
// - Key field powers up as 01010B.
// - Run-mode time-out resets and sets time-out flag.
// - Sleep time-out sets flags, clears PC/SP only.
// - Bad key write, clear, halt clear count.
// - Period spans 2^8 to 2^18 slow ticks.
// - Low-voltage reset off in idle/sleep.
// - Low supply must outlast selected width.
// - Qualified low voltage resets, sets cause.
// - Undefined select code resets, restores default.
// - Select register powers up as 01100110B.
// - Low-voltage reset keeps select register.
// - Width codes give 8/32/64/128 ticks, default 01.
// - Low-voltage cause flag cleared by writing zero.
// - Select fault flag set on undefined code.
// - Writing 55H to flash control resets.
// - Reset clears PC, ports go high.
// - Key fault flag set, software clears.
// - Period codes pick 2^8..2^18 ratios.
// - Halt sets power-down, clear instruction clears.
`ifndef WDT_RST_CFG_SVH
`define WDT_RST_CFG_SVH

`define OFS_WDT_CTRL 8'h00
`define OFS_LV_SEL 8'h04
`define OFS_LV_WIDTH 8'h08
`define OFS_RST_CAUSE 8'h0C
`define OFS_STATUS 8'h10
`define OFS_FLASH_CTRL1 8'h14
`define OFS_PORT_DATA 8'h18
`define OFS_PORT_DIR 8'h1C

`define WDT_CTRL_POR 8'h53
`define LV_SEL_POR 8'h66
`define LV_WIDTH_POR 2'h1
`define PORT_POR 8'hFF
`define FLASH_CTRL1_POR 8'h00

`define KEY_MSB 7
`define KEY_LSB 3
`define PSEL_MSB 2
`define KEY_DISABLE 5'h15
`define KEY_ENABLE 5'h0A
`define FLASH_RESET_MAGIC 8'h55

`define LV_CODE_0 8'h66
`define LV_CODE_1 8'h55
`define LV_CODE_2 8'h33
`define LV_CODE_3 8'h99
`define LV_CODE_4 8'hAA
`define LV_CODE_5 8'hF0

`define WDT_EXP_0 5'h08
`define WDT_EXP_1 5'h0A
`define WDT_EXP_2 5'h0C
`define WDT_EXP_3 5'h0E
`define WDT_EXP_4 5'h0F
`define WDT_EXP_5 5'h10
`define WDT_EXP_6 5'h11
`define WDT_EXP_7 5'h12

`define LV_WIDTH_0 8'h08
`define LV_WIDTH_1 8'h20
`define LV_WIDTH_2 8'h40
`define LV_WIDTH_3 8'h80

`define SYS_CLK_HZ 125000000
`define SYS_CLK_NS 8
`define SLOW_OSC_HZ 32000
`define SLOW_DIV_CYC (`SYS_CLK_HZ / `SLOW_OSC_HZ)
`define SRESET_NS 2000
`define SRESET_CYC ((`SRESET_NS + `SYS_CLK_NS - 1) / `SYS_CLK_NS)

`endif

//--- pkg/wdt_rst_pkg.sv
// Types shared by the watchdog and reset control block.
package wdt_rst_pkg;
  typedef enum logic [1:0] {
    SRST_IDLE = 2'h0,
    SRST_WAIT = 2'h1,
    SRST_FIRE = 2'h3
  } sreset_state_type;
endpackage

//--- testbench/test_watchdog_and_reset_control.sv
// Self-checking bench for the watchdog and reset control block.
`timescale 1ns/1ns
module test_watchdog_and_reset_control;
  logic clk_sys_i = 1'h0;
  logic nrst_i = 1'h0;
  logic wb_cyc_i = 1'h0;
  logic wb_stb_i = 1'h0;
  logic wb_we_i = 1'h0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'hF;
  logic [31:0] wb_dat_i = 32'h0;
  logic watchdog_clear_instruction_i = 1'h0;
  logic halt_i = 1'h0;
  logic low_power_i = 1'h0;
  logic supply_low_i = 1'h0;
  logic wb_ack_o, device_reset_o, pc_sp_clear_o, wakeup_o;
  logic timeout_status_flag_o, powerdown_flag_o;
  logic [31:0] wb_dat_o;
  logic [7:0] port_data_o, port_dir_o;
  logic [31:0] exp_q[$];
  logic [7:0] lv_codes[6] = '{8'h66, 8'h55, 8'h33, 8'h99, 8'hAA, 8'hF0};
  int n_errors = 0;
  int checked = 0;
  int n_rst = 0;
  int n_wk = 0;
  int b, c;

  watchdog_and_reset_control #(.SLOW_DIV(4), .SRESET_CYC(4)) u_dut (
    .clk_sys_i, .nrst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
    .wb_ack_o, .wb_dat_o, .watchdog_clear_instruction_i, .halt_i, .low_power_i,
    .supply_low_i,
    .device_reset_o, .pc_sp_clear_o, .wakeup_o, .timeout_status_flag_o,
    .powerdown_flag_o, .port_data_o, .port_dir_o);

  initial begin
    forever #4 clk_sys_i = ~clk_sys_i;
  end

  task automatic final_report();
    $display("checks %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] s);
    checked++;
    if (s !== e) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, s);
    end
  endtask

  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    wb_cyc_i <= 1'h1;
    wb_stb_i <= 1'h1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= {24'h0, d};
    do begin
      @(posedge clk_sys_i);
      n++;
    end while (wb_ack_o !== 1'h1 && n < 20);
    if (n >= 20) begin
      $display("CHECK FAILED bus ack expected 1 seen none");
      n_errors++;
      final_report();
    end
    wb_cyc_i <= 1'h0;
    wb_stb_i <= 1'h0;
    wb_we_i <= 1'h0;
    @(posedge clk_sys_i);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(1'h1, a, d);
  endtask

  // The expected value is queued before the request; the monitor pops it at ack.
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back({24'h0, e});
    bus(1'h0, a, 8'h00);
  endtask

  task automatic wait_ev(input logic wk, input int base, input int lim);
    int n;
    n = 0;
    while ((wk ? n_wk : n_rst) == base && n < lim) begin
      @(posedge clk_sys_i);
      n++;
    end
    if (n >= lim) begin
      $display("CHECK FAILED event pulse expected 1 seen none");
      n_errors++;
      final_report();
    end
  endtask

  task automatic pulse(input logic hlt);
    if (hlt) halt_i <= 1'h1;
    else watchdog_clear_instruction_i <= 1'h1;
    @(posedge clk_sys_i);
    halt_i <= 1'h0;
    watchdog_clear_instruction_i <= 1'h0;
    @(posedge clk_sys_i);
  endtask

  // Parks the watchdog with the disable key and a random period code.
  task automatic off();
    repeat (4) @(posedge clk_sys_i);
    wr(8'h00, {5'h15, 3'($urandom)});
  endtask

  always @(posedge clk_sys_i) begin
    if (wb_ack_o === 1'h1 && wb_we_i === 1'h0) begin
      if (exp_q.size() == 0) chk("unexpected read", 32'h0, wb_dat_o);
      else chk("read data", exp_q.pop_front(), wb_dat_o);
    end
    if (device_reset_o === 1'h1) n_rst <= n_rst + 1;
    if (wakeup_o === 1'h1) n_wk <= n_wk + 1;
  end

  initial begin
    void'($urandom(32'hD1D0CE00));
    repeat (10) @(posedge clk_sys_i);
    nrst_i <= 1'h1;
    @(posedge clk_sys_i);
    chk("port data", 32'hFF, {24'h0, port_data_o});
    rd(8'h00, 8'h53);
    rd(8'h04, 8'h66);
    rd(8'h08, 8'h01);
    rd(8'h0C, 8'h00);
    rd({3'h1, 3'($urandom), 2'h0}, 8'h00);
    $display("test power-on values done");
    b = n_rst;
    wr(8'h00, 8'hA8);
    repeat (1500) @(posedge clk_sys_i);
    chk("disabled reset", b, n_rst);
    $display("test disabled watchdog done");
    foreach (lv_codes[i]) begin
      wr(8'h04, lv_codes[i]);
      rd(8'h04, lv_codes[i]);
    end
    for (int i = 0; i < 4; i++) begin
      wr(8'h08, 8'(i));
      rd(8'h08, 8'(i));
    end
    $display("test select codes done");
    for (int p = 0; p < 2; p++) begin
      wr(8'h00, {5'h0A, 3'(p)});
      b = n_rst;
      repeat ((4 << (8 + 2 * p)) - 60) @(posedge clk_sys_i);
      chk("early reset", b, n_rst);
      wait_ev(1'h0, b, 200);
      rd(8'h10, 8'h01);
      rd(8'h00, 8'h53);
      off();
    end
    $display("test run time-out done");
    low_power_i <= 1'h1;
    wr(8'h00, 8'h50);
    pulse(1'h1);
    rd(8'h10, 8'h02);
    b = n_wk;
    c = n_rst;
    wait_ev(1'h1, b, 1200);
    chk("sleep reset", c, n_rst);
    rd(8'h10, 8'h03);
    rd(8'h00, 8'h50);
    low_power_i <= 1'h0;
    pulse(1'h0);
    rd(8'h10, 8'h01);
    off();
    $display("test sleep time-out done");
    wr(8'h04, 8'h33);
    wr(8'h08, 8'h00);
    b = n_rst;
    low_power_i <= 1'h1;
    supply_low_i <= 1'h1;
    repeat (200) @(posedge clk_sys_i);
    supply_low_i <= 1'h0;
    chk("idle low-voltage reset", b, n_rst);
    repeat (4) @(posedge clk_sys_i);
    low_power_i <= 1'h0;
    supply_low_i <= 1'h1;
    repeat ($urandom_range(20, 8)) @(posedge clk_sys_i);
    supply_low_i <= 1'h0;
    repeat (60) @(posedge clk_sys_i);
    chk("short dip reset", b, n_rst);
    supply_low_i <= 1'h1;
    wait_ev(1'h0, b, 100);
    supply_low_i <= 1'h0;
    rd(8'h0C, 8'h04);
    rd(8'h04, 8'h33);
    wr(8'h0C, 8'hFF);
    rd(8'h0C, 8'h04);
    wr(8'h0C, 8'h00);
    rd(8'h0C, 8'h00);
    off();
    $display("test low voltage done");
    b = n_rst;
    wr(8'h04, 8'h12);
    wait_ev(1'h0, b, 40);
    rd(8'h0C, 8'h02);
    rd(8'h04, 8'h66);
    wr(8'h0C, 8'h00);
    off();
    b = n_rst;
    wr(8'h00, {5'h00, 3'($urandom)});
    wait_ev(1'h0, b, 40);
    rd(8'h0C, 8'h01);
    wr(8'h0C, 8'h00);
    rd(8'h0C, 8'h00);
    rd(8'h00, 8'h53);
    off();
    $display("test bad codes done");
    wr(8'h18, 8'h3C);
    wr(8'h1C, 8'h0F);
    rd(8'h18, 8'h3C);
    b = n_rst;
    wr(8'h14, 8'h55);
    wait_ev(1'h0, b, 4);
    repeat (2) @(posedge clk_sys_i);
    chk("port dir", 32'hFF, {24'h0, port_dir_o});
    rd(8'h18, 8'hFF);
    nrst_i <= 1'h0;
    repeat (3) @(posedge clk_sys_i);
    nrst_i <= 1'h1;
    @(posedge clk_sys_i);
    rd(8'h00, 8'h53);
    $display("test flash and second reset done");
    final_report();
  end
endmodule

bind watchdog_and_reset_control wdt_rst_chk u_chk (
  .clk_sys_i, .nrst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
  .wb_ack_o, .watchdog_clear_instruction_i, .halt_i, .device_reset_o, .pc_sp_clear_o,
  .wakeup_o, .timeout_status_flag_o, .powerdown_flag_o, .port_data_o, .port_dir_o);

//--- testbench/wdt_rst_chk.sv
// Assertion checker for the watchdog and reset control block.
`timescale 1ns/1ns
module wdt_rst_chk (
  // Clock, reset and bus.
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic wb_ack_o,
  // Events and results.
  input wire logic watchdog_clear_instruction_i,
  input wire logic halt_i,
  input wire logic device_reset_o,
  input wire logic pc_sp_clear_o,
  input wire logic wakeup_o,
  input wire logic timeout_status_flag_o,
  input wire logic powerdown_flag_o,
  input wire logic [7:0] port_data_o,
  input wire logic [7:0] port_dir_o
);
  default clocking @(posedge clk_sys_i);
  endclocking
  default disable iff (!nrst_i);
  wire flash_wr = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0]
    && wb_adr_i == 8'h14 && wb_dat_i[7:0] == 8'h55;
  wire ports_high = port_data_o == 8'hFF && port_dir_o == 8'hFF;

  flash_reset_a: assert property (
    flash_wr |=> device_reset_o) else $error("flash magic write gave no reset");
  reset_clear_a: assert property (
    device_reset_o |-> pc_sp_clear_o ##1 !device_reset_o) else $error("reset pulse wrong");
  ports_reset_a: assert property (
    device_reset_o |-> ##[1:2] ports_high) else $error("ports not high after reset");
  ports_por_a: assert property (
    $rose(nrst_i) |-> ports_high) else $error("ports not high at power-on");
  wake_flags_a: assert property (
    wakeup_o |-> ##[0:1] (timeout_status_flag_o && powerdown_flag_o))
    else $error("sleep time-out flags not set");
  wake_quiet_a: assert property (
    wakeup_o |-> !device_reset_o ##[0:1] pc_sp_clear_o) else $error("sleep time-out action wrong");
  halt_pd_a: assert property (
    halt_i |=> powerdown_flag_o && !timeout_status_flag_o) else $error("halt flags wrong");
  clr_pd_a: assert property (
    watchdog_clear_instruction_i |=> !powerdown_flag_o)
    else $error("clear did not drop power-down flag");
endmodule

//--- verilog/low_speed_internal_osc_watchdog_counter.sv
// Watchdog count on the slow oscillator tick with selectable period.
`timescale 1ns/1ns
`include "wdt_rst_cfg.svh"
module slow_watchdog_counter #(
  parameter int unsigned CNT_W = 18
) (
  // Clock and reset.
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  // Control.
  input wire logic tick_i,
  input wire logic run_i,
  input wire logic clear_i,
  input wire logic [2:0] period_sel_i,
  // Result.
  output logic timeout_o
);
  logic [CNT_W-1:0] cnt_q;
  logic timeout_q;
  wire [CNT_W-1:0] last_cnt;
  wire at_last;

  function automatic logic [4:0] period_exp(input logic [2:0] sel);
    logic [4:0] e;
    e = `WDT_EXP_0;
    case (sel)
      3'h0: e = `WDT_EXP_0;
      3'h1: e = `WDT_EXP_1;
      3'h2: e = `WDT_EXP_2;
      3'h3: e = `WDT_EXP_3;
      3'h4: e = `WDT_EXP_4;
      3'h5: e = `WDT_EXP_5;
      3'h6: e = `WDT_EXP_6;
      default: e = `WDT_EXP_7;
    endcase
    return e;
  endfunction

  assign last_cnt = CNT_W'((64'h1 << period_exp(period_sel_i)) - 64'h1);
  assign at_last = (cnt_q >= last_cnt);

  // A disabled watchdog is held cleared and stopped.
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cnt_q <= '0;
      timeout_q <= 1'b0;
    end else begin
      timeout_q <= 1'b0;
      if (clear_i || !run_i) begin
        cnt_q <= '0;
      end else if (tick_i) begin
        if (at_last) begin
          cnt_q <= '0;
          timeout_q <= 1'b1;
        end else begin
          cnt_q <= cnt_q + 1'b1;
        end
      end
    end
  end

  assign timeout_o = timeout_q;
endmodule

//--- verilog/watchdog_and_reset_control.sv
// Watchdog, low-voltage reset filter and reset-cause logic behind a Wishbone slave.
`timescale 1ns/1ns
`include "wdt_rst_cfg.svh"
module watchdog_and_reset_control #(
  parameter int unsigned SLOW_DIV = `SLOW_DIV_CYC,
  parameter int unsigned SRESET_CYC = `SRESET_CYC,
  parameter int unsigned CNT_W = 18
) (
  // Clock and reset.
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  // Wishbone slave.
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic wb_ack_o,
  output logic [31:0] wb_dat_o,
  // Processor events.
  input wire logic watchdog_clear_instruction_i,
  input wire logic halt_i,
  input wire logic low_power_i,
  // Supply monitor, asynchronous.
  input wire logic supply_low_i,
  // Reset actions and status.
  output logic device_reset_o,
  output logic pc_sp_clear_o,
  output logic wakeup_o,
  output logic timeout_status_flag_o,
  output logic powerdown_flag_o,
  // Port defaults.
  output logic [7:0] port_data_o,
  output logic [7:0] port_dir_o
);
  // Bus state.
  logic ack_q;
  logic [31:0] dat_q;
  logic [7:0] rd_byte;

  // Registers.
  logic [7:0] wdt_control_register_q;
  logic [7:0] low_voltage_select_q;
  logic [1:0] lowvolt_width_select_q;
  logic lowvolt_reset_cause_flag_q;
  logic lowvolt_select_fault_flag_q;
  logic wdt_key_fault_flag_q;
  logic timeout_status_flag_q;
  logic powerdown_flag_q;
  logic [7:0] flash_control_one_q;
  logic [7:0] port_data_q;
  logic [7:0] port_dir_q;

  // Reset outputs.
  logic device_reset_q;
  logic pc_sp_clear_q;
  logic wakeup_q;

  // Slow oscillator tick.
  logic [15:0] div_q;
  logic slow_tick_q;

  // Software reset delay.
  wdt_rst_pkg::sreset_state_type srst_q;
  wdt_rst_pkg::sreset_state_type srst_d;
  logic [15:0] srst_cnt_q;

  // Low-voltage filter.
  logic lv_meta_q;
  logic lv_sync_q;
  logic [7:0] lv_cnt_q;
  logic lv_fired_q;

  function automatic logic key_is_bad(input logic [4:0] key);
    return (key != `KEY_ENABLE) && (key != `KEY_DISABLE);
  endfunction

  function automatic logic lv_code_ok(input logic [7:0] code);
    return (code == `LV_CODE_0) || (code == `LV_CODE_1) || (code == `LV_CODE_2) ||
           (code == `LV_CODE_3) || (code == `LV_CODE_4) || (code == `LV_CODE_5);
  endfunction

  function automatic logic [7:0] lv_width(input logic [1:0] sel);
    logic [7:0] w;
    w = `LV_WIDTH_1;
    case (sel)
      2'h0: w = `LV_WIDTH_0;
      2'h1: w = `LV_WIDTH_1;
      2'h2: w = `LV_WIDTH_2;
      default: w = `LV_WIDTH_3;
    endcase
    return w;
  endfunction

  // Bus decode.
  wire bus_req = wb_cyc_i & wb_stb_i & ~ack_q;
  wire wr_en = bus_req & wb_we_i & wb_sel_i[0];
  wire [7:0] wr_byte = wb_dat_i[7:0];
  wire wr_wdt_ctl = wr_en & (wb_adr_i == `OFS_WDT_CTRL);
  wire wr_lvs = wr_en & (wb_adr_i == `OFS_LV_SEL);
  wire wr_lvw = wr_en & (wb_adr_i == `OFS_LV_WIDTH);
  wire wr_cause = wr_en & (wb_adr_i == `OFS_RST_CAUSE);
  wire wr_flash_ctl = wr_en & (wb_adr_i == `OFS_FLASH_CTRL1);
  wire wr_pdat = wr_en & (wb_adr_i == `OFS_PORT_DATA);
  wire wr_pdir = wr_en & (wb_adr_i == `OFS_PORT_DIR);

  // Watchdog key decode.
  wire [4:0] wdt_key_field = wdt_control_register_q[`KEY_MSB:`KEY_LSB];
  wire [2:0] wdt_period_select = wdt_control_register_q[`PSEL_MSB:0];
  wire wdt_run = (wdt_key_field == `KEY_ENABLE);
  wire key_bad = key_is_bad(wdt_key_field);
  wire key_bad_wr = wr_wdt_ctl & key_is_bad(wr_byte[`KEY_MSB:`KEY_LSB]);
  wire lvs_bad = ~lv_code_ok(low_voltage_select_q);

  // Reset sources.
  wire wdt_timeout;
  wire timeout_run = wdt_timeout & ~low_power_i;
  wire timeout_sleep = wdt_timeout & low_power_i;
  wire sreset_fire = (srst_q == wdt_rst_pkg::SRST_FIRE);
  wire flash_magic = wr_flash_ctl & (wr_byte == `FLASH_RESET_MAGIC);
  wire lv_rst_en = ~low_power_i;
  wire lv_at_width = (lv_cnt_q == lv_width(lowvolt_width_select_q) - 8'h01);
  wire lv_rst_fire = lv_rst_en & lv_sync_q & slow_tick_q & lv_at_width & ~lv_fired_q;
  wire restore_all = timeout_run | sreset_fire | flash_magic;
  wire reset_any = restore_all | lv_rst_fire;
  wire wdt_clear = watchdog_clear_instruction_i | halt_i | key_bad_wr | reset_any;

  // Read selection.
  always_comb begin
    rd_byte = 8'h00;
    if (wb_adr_i == `OFS_WDT_CTRL) begin
      rd_byte = wdt_control_register_q;
    end else if (wb_adr_i == `OFS_LV_SEL) begin
      rd_byte = low_voltage_select_q;
    end else if (wb_adr_i == `OFS_LV_WIDTH) begin
      rd_byte = {6'h00, lowvolt_width_select_q};
    end else if (wb_adr_i == `OFS_RST_CAUSE) begin
      rd_byte = {5'h00, lowvolt_reset_cause_flag_q, lowvolt_select_fault_flag_q,
                 wdt_key_fault_flag_q};
    end else if (wb_adr_i == `OFS_STATUS) begin
      rd_byte = {6'h00, powerdown_flag_q, timeout_status_flag_q};
    end else if (wb_adr_i == `OFS_FLASH_CTRL1) begin
      rd_byte = flash_control_one_q;
    end else if (wb_adr_i == `OFS_PORT_DATA) begin
      rd_byte = port_data_q;
    end else if (wb_adr_i == `OFS_PORT_DIR) begin
      rd_byte = port_dir_q;
    end
  end

  // Every access, mapped or not, is answered one cycle later.
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ack_q <= 1'b0;
      dat_q <= 32'h0000_0000;
    end else begin
      ack_q <= bus_req;
      if (bus_req && !wb_we_i) begin
        dat_q <= {24'h00_0000, rd_byte};
      end
    end
  end

  // The slow oscillator is modelled as a tick divided from the system clock.
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      div_q <= 16'h0000;
      slow_tick_q <= 1'b0;
    end else begin
      slow_tick_q <= (div_q == 16'(SLOW_DIV - 1));
      if (div_q == 16'(SLOW_DIV - 1)) begin
        div_q <= 16'h0000;
      end else begin
        div_q <= div_q + 16'h0001;
      end
    end
  end

  slow_watchdog_counter #(
    .CNT_W(CNT_W)
  ) u_wdt_cnt (
    .clk_sys_i(clk_sys_i),
    .nrst_i(nrst_i),
    .tick_i(slow_tick_q),
    .run_i(wdt_run),
    .clear_i(wdt_clear),
    .period_sel_i(wdt_period_select),
    .timeout_o(wdt_timeout)
  );

  // Key register; any internal reset returns it to its power-on value.
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wdt_control_register_q <= `WDT_CTRL_POR;
    end else if (reset_any) begin
      wdt_control_register_q <= `WDT_CTRL_POR;
    end else if (wr_wdt_ctl) begin
      wdt_control_register_q <= wr_byte;
    end
  end

  // Select and width registers survive a genuine low-voltage reset.
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      low_voltage_select_q <= `LV_SEL_POR;
      lowvolt_width_select_q <= `LV_WIDTH_POR;
    end else if (restore_all) begin
      low_voltage_select_q <= `LV_SEL_POR;
      lowvolt_width_select_q <= `LV_WIDTH_POR;
    end else begin
      if (wr_lvs) begin
        low_voltage_select_q <= wr_byte;
      end
      if (wr_lvw) begin
        lowvolt_width_select_q <= wr_byte[1:0];
      end
    end
  end

  // A bad key or select code is held for the delay, then resets.
  always_comb begin
    srst_d = srst_q;
    case (srst_q)
      wdt_rst_pkg::SRST_IDLE: begin
        if (key_bad || lvs_bad) begin
          srst_d = wdt_rst_pkg::SRST_WAIT;
        end
      end
      wdt_rst_pkg::SRST_WAIT: begin
        if (srst_cnt_q == 16'(SRESET_CYC - 1)) begin
          srst_d = wdt_rst_pkg::SRST_FIRE;
        end
      end
      default: begin
        srst_d = wdt_rst_pkg::SRST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      srst_q <= wdt_rst_pkg::SRST_IDLE;
      srst_cnt_q <= 16'h0000;
    end else begin
      srst_q <= srst_d;
      if (srst_q == wdt_rst_pkg::SRST_WAIT) begin
        srst_cnt_q <= srst_cnt_q + 16'h0001;
      end else begin
        srst_cnt_q <= 16'h0000;
      end
    end
  end

  // The supply indication comes from the analog monitor.
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      lv_meta_q <= 1'b0;
      lv_sync_q <= 1'b0;
    end else begin
      lv_meta_q <= supply_low_i;
      lv_sync_q <= lv_meta_q;
    end
  end

  // Short low pulses restart the filter; one reset per low period.
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      lv_cnt_q <= 8'h00;
      lv_fired_q <= 1'b0;
    end else if (!lv_sync_q || !lv_rst_en) begin
      lv_cnt_q <= 8'h00;
      lv_fired_q <= 1'b0;
    end else if (lv_rst_fire) begin
      lv_fired_q <= 1'b1;
    end else if (slow_tick_q && !lv_at_width && !lv_fired_q) begin
      lv_cnt_q <= lv_cnt_q + 8'h01;
    end
  end

  // Cause flags; a set in the cycle of a clearing write wins.
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      lowvolt_reset_cause_flag_q <= 1'b0;
      lowvolt_select_fault_flag_q <= 1'b0;
      wdt_key_fault_flag_q <= 1'b0;
    end else begin
      lowvolt_reset_cause_flag_q <= lv_rst_fire |
          (lowvolt_reset_cause_flag_q & ~(wr_cause & ~wr_byte[2]));
      lowvolt_select_fault_flag_q <= lvs_bad |
          (lowvolt_select_fault_flag_q & ~(wr_cause & ~wr_byte[1]));
      wdt_key_fault_flag_q <= key_bad |
          (wdt_key_fault_flag_q & ~(wr_cause & ~wr_byte[0]));
    end
  end

  // Status flags; a low-voltage or software reset leaves them unchanged.
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      timeout_status_flag_q <= 1'b0;
      powerdown_flag_q <= 1'b0;
    end else begin
      timeout_status_flag_q <= wdt_timeout | (timeout_status_flag_q & ~halt_i);
      powerdown_flag_q <= halt_i | timeout_sleep |
          (powerdown_flag_q & ~watchdog_clear_instruction_i);
    end
  end

  // Flash control and port registers.
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      flash_control_one_q <= `FLASH_CTRL1_POR;
      port_data_q <= `PORT_POR;
      port_dir_q <= `PORT_POR;
    end else if (reset_any) begin
      flash_control_one_q <= `FLASH_CTRL1_POR;
      port_data_q <= `PORT_POR;
      port_dir_q <= `PORT_POR;
    end else begin
      if (wr_flash_ctl) begin
        flash_control_one_q <= wr_byte;
      end
      if (wr_pdat) begin
        port_data_q <= wr_byte;
      end
      if (wr_pdir) begin
        port_dir_q <= wr_byte;
      end
    end
  end

  // A sleep time-out only wakes the core and clears its PC and stack pointer.
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      device_reset_q <= 1'b0;
      pc_sp_clear_q <= 1'b1;
      wakeup_q <= 1'b0;
    end else begin
      device_reset_q <= reset_any;
      pc_sp_clear_q <= reset_any | timeout_sleep;
      wakeup_q <= timeout_sleep;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;
  assign device_reset_o = device_reset_q;
  assign pc_sp_clear_o = pc_sp_clear_q;
  assign wakeup_o = wakeup_q;
  assign timeout_status_flag_o = timeout_status_flag_q;
  assign powerdown_flag_o = powerdown_flag_q;
  assign port_data_o = port_data_q;
  assign port_dir_o = port_dir_q;
endmodule
